// file: src/aee_defines.svh
`ifndef AEE_DEFINES_SVH
`define AEE_DEFINES_SVH

// register byte offsets
`define AEE_OFF_SWITCH      12'h000
`define AEE_OFF_PULSE       12'h004
`define AEE_OFF_CONTROL     12'h008
`define AEE_OFF_STATUS      12'h00c
`define AEE_OFF_ACTIVE      12'h010
`define AEE_OFF_REVCOUNT    12'h014

// field positions
`define AEE_BIT_ENC_TYPE    9
`define AEE_BIT_REQ_IGNORE  0
`define AEE_BIT_SETUP       0

// reset and encoder values
`define AEE_SWITCH_RST      32'h0000_0000
`define AEE_PULSE_RST       16'h0800
`define AEE_PULSE_ABS       16'h0400
`define AEE_PULSE_INC       16'h0800

// timing
`define AEE_CLK_HZ          10000000
`define AEE_PWR_SETTLE_MS   100
`define AEE_NORMAL_MS       50
`define AEE_SERIAL_BYTES    8
`define AEE_BYTE_US         1042

`endif

// file: src/aee_pkg.sv
package aee_pkg;
  typedef enum logic [2:0] {
    AEE_IDLE,
    AEE_POWER,
    AEE_SERIAL,
    AEE_PULSES,
    AEE_NORMAL
  } aee_state_t;

  typedef logic [31:0] aee_word_t;
endpackage

// file: src/aee_seq.sv
`timescale 1ns/1ns
`include "aee_defines.svh"
module aee_seq #(
  parameter int unsigned SETTLE_CYC = 1000000,
  parameter int unsigned BYTE_CYC   = 10420,
  parameter int unsigned NORMAL_CYC = 500000
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  aee_seq_if.seq    seq,
  output logic      enc_power_out,
  output logic      serial_byte_out,
  output logic      init_pulse_out
);
  aee_pkg::aee_state_t state_r;
  logic [31:0]         cnt_r;
  logic [3:0]          bytes_r;

  // power, serial bytes, initial pulses, then normal
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= aee_pkg::AEE_IDLE;
      cnt_r   <= 32'h0;
      bytes_r <= 4'h0;
    end else begin
      unique case (state_r)
        aee_pkg::AEE_IDLE: begin
          cnt_r   <= 32'h0;
          bytes_r <= 4'h0;
          if (seq.start) begin
            state_r <= aee_pkg::AEE_POWER;
          end
        end
        aee_pkg::AEE_POWER: begin
          if (cnt_r >= SETTLE_CYC - 1) begin
            cnt_r   <= 32'h0;
            state_r <= aee_pkg::AEE_SERIAL;
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
        aee_pkg::AEE_SERIAL: begin
          if (cnt_r >= BYTE_CYC - 1) begin
            cnt_r   <= 32'h0;
            bytes_r <= bytes_r + 4'h1;
            if (bytes_r == 4'(`AEE_SERIAL_BYTES - 1)) begin
              state_r <= aee_pkg::AEE_PULSES;
            end
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
        aee_pkg::AEE_PULSES: begin
          if (cnt_r >= NORMAL_CYC - 1) begin
            cnt_r   <= 32'h0;
            state_r <= aee_pkg::AEE_NORMAL;
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
        aee_pkg::AEE_NORMAL: begin
          cnt_r <= 32'h0;
          if (seq.start) begin
            state_r <= aee_pkg::AEE_POWER;
          end
        end
      endcase
    end
  end

  // registered status and strobes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enc_power_out   <= 1'b0;
      serial_byte_out <= 1'b0;
      init_pulse_out  <= 1'b0;
      seq.done        <= 1'b0;
      seq.busy        <= 1'b0;
    end else begin
      enc_power_out   <= (state_r != aee_pkg::AEE_IDLE);
      serial_byte_out <= (state_r == aee_pkg::AEE_SERIAL) &&
                         (cnt_r == 32'h0);
      init_pulse_out  <= (state_r == aee_pkg::AEE_PULSES);
      seq.done        <= (state_r == aee_pkg::AEE_NORMAL);
      seq.busy        <= (state_r != aee_pkg::AEE_IDLE) &&
                         (state_r != aee_pkg::AEE_NORMAL);
    end
  end
endmodule

// file: src/aee_seq_if.sv
`timescale 1ns/1ns
interface aee_seq_if;
  logic start;
  logic done;
  logic busy;
  modport ctrl (output start, input done, input busy);
  modport seq  (input start, output done, output busy);
endinterface

// file: src/aee_top.sv
`timescale 1ns/1ns
`include "aee_defines.svh"
module aee_top #(
  parameter int unsigned SETTLE_CYC = (`AEE_CLK_HZ / 1000) *
                                      `AEE_PWR_SETTLE_MS,
  parameter int unsigned BYTE_CYC   = (`AEE_CLK_HZ / 1000000) *
                                      `AEE_BYTE_US,
  parameter int unsigned NORMAL_CYC = (`AEE_CLK_HZ / 1000) *
                                      `AEE_NORMAL_MS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        encoder_request_in,
  input  wire logic        servo_enable_in,
  input  wire logic        backup_battery_input_in,
  input  wire logic        s_axi_awvalid_in,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_bready_in,
  input  wire logic        s_axi_arvalid_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_rready_in,
  output logic             s_axi_awready_out,
  output logic             s_axi_wready_out,
  output logic             s_axi_bvalid_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_arready_out,
  output logic             s_axi_rvalid_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             enc_power_out,
  output logic             motor_enable_out,
  output logic             serial_byte_out,
  output logic             init_pulse_out,
  output logic [15:0]      encoder_pulses_per_rev_out
);
  aee_seq_if            sq ();
  aee_pkg::aee_word_t   switch_r = `AEE_SWITCH_RST; // factory value
  logic [15:0]          pulse_r  = `AEE_PULSE_RST;  // factory value
  logic                 act_abs_r;
  logic [15:0]          act_pulse_r;
  logic                 ignore_r;
  logic                 latched_r;
  logic                 req_s1_r;
  logic                 req_s2_r;
  logic                 req_d_r;
  logic                 req_rise;
  logic                 start_nxt;
  logic [16:0]          rev_r;
  logic                 aw_got_r;
  logic                 w_got_r;
  logic [11:0]          awaddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 wr_fire;
  logic                 wr_ok;
  logic [31:0]          rd_word;
  logic                 rd_ok;

  // byte lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // decode of mapped offsets
  function automatic logic mapped(input logic [11:0] a);
    return (a == `AEE_OFF_SWITCH) || (a == `AEE_OFF_PULSE) ||
           (a == `AEE_OFF_CONTROL) || (a == `AEE_OFF_STATUS) ||
           (a == `AEE_OFF_ACTIVE) || (a == `AEE_OFF_REVCOUNT);
  endfunction

  aee_seq #(
    .SETTLE_CYC (SETTLE_CYC),
    .BYTE_CYC   (BYTE_CYC),
    .NORMAL_CYC (NORMAL_CYC)
  ) u_seq (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .seq             (sq.seq),
    .enc_power_out   (enc_power_out),
    .serial_byte_out (serial_byte_out),
    .init_pulse_out  (init_pulse_out)
  );

  // two stage synchroniser and edge detect
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_d_r  <= 1'b0;
    end else begin
      req_s1_r <= encoder_request_in;
      req_s2_r <= req_s1_r;
      req_d_r  <= req_s2_r;
    end
  end
  assign req_rise = req_s2_r & ~req_d_r;

  // settings taken once after reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latched_r   <= 1'b0;
      act_abs_r   <= 1'b0;
      act_pulse_r <= `AEE_PULSE_INC;
      ignore_r    <= 1'b0;
    end else if (!latched_r) begin
      latched_r   <= 1'b1;
      act_abs_r   <= switch_r[`AEE_BIT_ENC_TYPE];
      act_pulse_r <= switch_r[`AEE_BIT_ENC_TYPE] ? `AEE_PULSE_ABS
                                                  : pulse_r;
      ignore_r    <= switch_r[`AEE_BIT_REQ_IGNORE];
    end
  end

  // absolute type only: start on request edge, or at once when ignored
  always_comb begin
    start_nxt = 1'b0;
    if (latched_r && act_abs_r) begin
      if (ignore_r) begin
        start_nxt = !sq.busy && !sq.done && !enc_power_out;
      end else begin
        start_nxt = req_rise;
      end
    end
  end
  assign sq.start = start_nxt;

  // motor held off until sequence finished, for the absolute type only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      motor_enable_out           <= 1'b0;
      encoder_pulses_per_rev_out <= `AEE_PULSE_INC;
    end else begin
      motor_enable_out <= servo_enable_in && latched_r &&
                          (!act_abs_r || (sq.done && !start_nxt));
      encoder_pulses_per_rev_out <= act_pulse_r;
    end
  end

  // revolution count, zeroed by setup
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rev_r <= 17'h0;
    end else if (wr_fire && awaddr_r == `AEE_OFF_CONTROL &&
                 wstrb_r[0] && wdata_r[`AEE_BIT_SETUP]) begin
      rev_r <= 17'h0;
    end else if (wr_fire && awaddr_r == `AEE_OFF_REVCOUNT) begin
      rev_r <= 17'(merge({15'h0, rev_r}, wdata_r, wstrb_r));
    end
  end

  // stored settings survive reset, which stands for a power cycle
  always_ff @(posedge clk_in) begin
    if (wr_fire && awaddr_r == `AEE_OFF_SWITCH) begin
      switch_r <= merge(switch_r, wdata_r, wstrb_r);
    end else if (wr_fire && awaddr_r == `AEE_OFF_PULSE) begin
      pulse_r <= 16'(merge({16'h0, pulse_r}, wdata_r, wstrb_r));
    end
  end

  // axi write channel capture
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid_out;
  assign wr_ok   = mapped(awaddr_r) && awaddr_r != `AEE_OFF_STATUS &&
                   awaddr_r != `AEE_OFF_ACTIVE;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_got_r          <= 1'b0;
      w_got_r           <= 1'b0;
      awaddr_r          <= 12'h0;
      wdata_r           <= 32'h0;
      wstrb_r           <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'h0;
    end else begin
      s_axi_awready_out <= !aw_got_r && !s_axi_awready_out;
      s_axi_wready_out  <= !w_got_r && !s_axi_wready_out;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr_in[11:2], 2'h0};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        aw_got_r         <= 1'b0;
        w_got_r          <= 1'b0;
      end
    end
  end

  // read mux; battery level is not watched here
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0;
    unique case ({s_axi_araddr_in[11:2], 2'h0})
      `AEE_OFF_SWITCH:   rd_word = switch_r;
      `AEE_OFF_PULSE:    rd_word = {16'h0, pulse_r};
      `AEE_OFF_CONTROL:  rd_word = 32'h0;
      `AEE_OFF_STATUS:   rd_word = {27'h0, motor_enable_out, sq.done,
                                    sq.busy, enc_power_out,
                                    req_s2_r};
      `AEE_OFF_ACTIVE:   rd_word = {14'h0, ignore_r, act_abs_r,
                                    act_pulse_r};
      `AEE_OFF_REVCOUNT: rd_word = {15'h0, rev_r};
      default:           rd_ok = 1'b0;
    endcase
  end

  // axi read channel
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0;
      s_axi_rresp_out   <= 2'h0;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rd_word;
        s_axi_rresp_out  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end
endmodule

// file: testbench/aee_host.sv
`timescale 1ns/1ns
module aee_host #(
  parameter int unsigned WAIT_CYC = 300
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        serial_byte_in,
  input  wire logic        init_pulse_in,
  output logic             encoder_request_out,
  output logic [3:0]       bytes_out,
  output logic [15:0]      pulses_out
);
  logic [15:0] wait_r;
  // raise the request after each power up settles, then keep it high
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_r              <= 16'h0;
      encoder_request_out <= 1'b0;
    end else if (wait_r != 16'(WAIT_CYC)) begin
      wait_r <= wait_r + 16'h1;
    end else begin
      encoder_request_out <= 1'b1;
    end
  end
  // receive phase A bytes, count initial pulses from zero
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bytes_out <= 4'h0;
      pulses_out <= 16'h0;
    end else begin
      if (serial_byte_in) bytes_out <= bytes_out + 4'h1;
      if (init_pulse_in) pulses_out <= pulses_out + 16'h1;
    end
  end
endmodule

// file: testbench/aee_top_asserts.sv
`timescale 1ns/1ns
module aee_top_chk #(
  parameter int unsigned NORMAL_CYC = 500000
) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        encoder_request_in,
  input wire logic        servo_enable_in,
  input wire logic        enc_power_out,
  input wire logic        motor_enable_out,
  input wire logic        serial_byte_out,
  input wire logic        init_pulse_out,
  input wire logic [15:0] encoder_pulses_per_rev_out
);
  logic [3:0]  nb_r;
  logic [31:0] ip_r;
  logic        dn_r;
  logic [3:0]  sr_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // bytes sent while the encoder is powered
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nb_r <= 4'h0;
    end else if (enc_power_out) begin
      nb_r <= nb_r + 4'(serial_byte_out);
    end
  end
  // initial pulse length and end of the power-up sequence
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ip_r <= 32'h0;
      dn_r <= 1'b0;
    end else begin
      ip_r <= init_pulse_out ? ip_r + 32'h1 : 32'h0;
      dn_r <= dn_r | (!init_pulse_out && ip_r != 32'h0);
    end
  end
  // cycles since reset release, saturating
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sr_r <= 4'h0;
    end else if (sr_r != 4'hf) begin
      sr_r <= sr_r + 4'h1;
    end
  end
  sequence s_req_rise;
    $rose(encoder_request_in) && !enc_power_out &&
    encoder_pulses_per_rev_out == 16'h0400;
  endsequence
  sequence s_pwr_on;
    ##[2:6] enc_power_out;
  endsequence
  AST_REQ_POWER: assert property (s_req_rise |-> s_pwr_on)
    else $error("encoder power late");
  AST_PWR_CAUSE: assert property ($rose(enc_power_out) |->
    $past(encoder_request_in, 2) || !$past(rst_n_in, 4))
    else $error("power without request");
  AST_BYTE_GAP: assert property (serial_byte_out |=>
    !serial_byte_out [*4]) else $error("bytes too close");
  AST_BYTE_CNT: assert property ($rose(init_pulse_out) |->
    nb_r == 4'h8) else $error("byte count wrong");
  AST_INIT_LEN: assert property ($fell(init_pulse_out) |->
    ip_r == NORMAL_CYC) else $error("initial pulse length wrong");
  AST_MOTOR_OFF: assert property (!dn_r &&
    encoder_pulses_per_rev_out == 16'h0400 |-> !motor_enable_out)
    else $error("motor on before sequence end");
  AST_MOTOR_SON: assert property (dn_r && $past(dn_r, 2) |->
    motor_enable_out == $past(servo_enable_in))
    else $error("motor not following servo enable");
  AST_PULSES: assert property (!$stable(encoder_pulses_per_rev_out) |->
    sr_r < 4'h4) else $error("pulse count changed without power cycle");
endmodule

bind aee_top aee_top_chk #(.NORMAL_CYC(NORMAL_CYC)) u_aee_top_chk (
  .clk_in, .rst_n_in, .encoder_request_in, .servo_enable_in,
  .enc_power_out, .motor_enable_out, .serial_byte_out, .init_pulse_out,
  .encoder_pulses_per_rev_out);

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`include "aee_defines.svh"
module tb_top;
  localparam int unsigned NORMAL_CYC = 10;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        son      = 1'b1;
  logic        batt     = 1'b0;
  logic        aw_v     = 1'b0;
  logic        w_v      = 1'b0;
  logic        b_rdy    = 1'b0;
  logic        ar_v     = 1'b0;
  logic        r_rdy    = 1'b0;
  logic [11:0] aw_a     = 12'h000;
  logic [11:0] ar_a     = 12'h000;
  logic [31:0] w_d      = 32'h0;
  logic        req, aw_r, w_r, b_v, ar_r, r_v, pwr, mot, sb, ip;
  logic [1:0]  b_rs, r_rs;
  logic [31:0] r_d;
  logic [15:0] ppr, npl;
  logic [3:0]  nby;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          cyc         = 0;

  always #50 clk_in = ~clk_in;

  aee_top #(.SETTLE_CYC(20), .BYTE_CYC(5), .NORMAL_CYC(NORMAL_CYC))
  u_aee_top (
    .clk_in, .rst_n_in, .encoder_request_in(req), .servo_enable_in(son),
    .backup_battery_input_in(batt), .s_axi_awvalid_in(aw_v),
    .s_axi_awaddr_in(aw_a), .s_axi_wvalid_in(w_v), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(4'hf), .s_axi_bready_in(b_rdy),
    .s_axi_arvalid_in(ar_v), .s_axi_araddr_in(ar_a),
    .s_axi_rready_in(r_rdy), .s_axi_awready_out(aw_r),
    .s_axi_wready_out(w_r), .s_axi_bvalid_out(b_v),
    .s_axi_bresp_out(b_rs), .s_axi_arready_out(ar_r),
    .s_axi_rvalid_out(r_v), .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_rs),
    .enc_power_out(pwr), .motor_enable_out(mot), .serial_byte_out(sb),
    .init_pulse_out(ip), .encoder_pulses_per_rev_out(ppr));

  aee_host #(.WAIT_CYC(300)) u_aee_host (
    .clk_in, .rst_n_in, .serial_byte_in(sb), .init_pulse_in(ip),
    .encoder_request_out(req), .bytes_out(nby), .pulses_out(npl));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // final report
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // register write, address and data released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_in);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    do begin
      @(posedge clk_in);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!b_v);
    r = b_rs;
    b_rdy <= 1'b0;
  endtask

  // register read
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_in);
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    do begin
      @(posedge clk_in);
      if (ar_r) ar_v <= 1'b0;
    end while (!r_v);
    d = r_d;
    r = r_rs;
    r_rdy <= 1'b0;
  endtask

  // settings written now stay pending until the next power cycle
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    wr(`AEE_OFF_SWITCH, 32'h0000_0201, r);
    rd(`AEE_OFF_SWITCH, d, r);
    chk(d, 32'h0000_0201);
    wr(`AEE_OFF_PULSE, 32'h0000_0400, r);
    rd(`AEE_OFF_PULSE, d, r);
    chk(d, 32'h0000_0400);
    rd(`AEE_OFF_ACTIVE, d, r);
    chk(32'(d[15:0]), 32'h0000_0800);
    chk(32'(ppr), 32'h0000_0800);
    chk(32'(pwr), 32'h0);
    rd(12'h100, d, r);
    chk(32'(r), 32'h2);
    wr(`AEE_OFF_STATUS, 32'h1, r);
    chk(32'(r), 32'h2);
  endtask

  // setup clears the revolution count
  task automatic t_setup();
    logic [31:0] d;
    logic [1:0]  r;
    wr(`AEE_OFF_REVCOUNT, 32'h0001_2345, r);
    rd(`AEE_OFF_REVCOUNT, d, r);
    chk(d, 32'h0001_2345);
    wr(`AEE_OFF_CONTROL, 32'h1, r);
    rd(`AEE_OFF_REVCOUNT, d, r);
    chk(d, 32'h0);
  endtask

  // reset pulse standing for a power cycle
  task automatic pwr_cycle();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask

  // sequence watch: motor off until initial pulses end, then on
  task automatic seq_watch();
    while (!pwr) @(posedge clk_in);
    while (npl == 16'h0 || ip) begin
      @(posedge clk_in);
      chk(32'(mot), 32'h0);
    end
    chk(32'(nby), 32'h8);
    chk(32'(npl), NORMAL_CYC);
    repeat (3) @(posedge clk_in);
    chk(32'(mot), 32'h1);
  endtask

  // ignore mode after power cycle: sequence starts by itself
  task automatic t_seq();
    logic [31:0] d;
    logic [1:0]  r;
    pwr_cycle();
    rd(`AEE_OFF_ACTIVE, d, r);
    chk(d, 32'h0003_0400);
    chk(32'(ppr), 32'h0000_0400);
    batt <= 1'b1;
    seq_watch();
    son <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(32'(mot), 32'h0);
  endtask

  // request mode: no power until the host raises the request
  task automatic t_req();
    logic [1:0] r;
    wr(`AEE_OFF_SWITCH, 32'h0000_0200, r);
    pwr_cycle();
    son <= 1'b1;
    while (!req) @(posedge clk_in);
    chk(32'(pwr), 32'h0);
    repeat (6) @(posedge clk_in);
    chk(32'(pwr), 32'h1);
    seq_watch();
  endtask

  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_regs();
    t_setup();
    t_seq();
    t_req();
    close_out();
  end
endmodule
